// *** common/crxb_defines.svh ***
// Purpose: constants for the receive buffering block
// Assumes: assembly buffer laid out as id bytes, length byte, eight data bytes
// Notes: definitions only
`ifndef CRXB_DEFINES_SVH
`define CRXB_DEFINES_SVH

`define CRXB_AB_BYTES 13
`define CRXB_AB_W 104
`define CRXB_NFILT 6
`define CRXB_B0_NFILT 2
`define CRXB_ID_W 29
`define CRXB_SID_W 11
`define CRXB_EID_W 18
`define CRXB_IDX_SIDH 0
`define CRXB_IDX_SIDL 1
`define CRXB_IDX_EID8 2
`define CRXB_IDX_EID0 3
`define CRXB_IDX_DLC 4
`define CRXB_SIDL_EXT_BIT 3
`define CRXB_SIDL_SRR_BIT 4
`define CRXB_DLC_RTR_BIT 6
`define CRXB_CTRL_RST 8'h00
`define CRXB_BYTE_ZERO 8'h00

`endif

// *** common/crxb_pkg.sv ***
// Purpose: types shared by the receive buffering block
// Assumes: defines header on the include path
// Notes: filter entries travel as one packed struct
`include "crxb_defines.svh"

package crxb_pkg;

  typedef enum logic [1:0] {
    CRXB_RXM_FILT = 2'h0,
    CRXB_RXM_STD = 2'h1,
    CRXB_RXM_EXT = 2'h2,
    CRXB_RXM_ANY = 2'h3
  } crxb_rxm_t;

  typedef struct packed {
    logic ext;
    logic [`CRXB_ID_W-1:0] id;
  } crxb_filt_t;

endpackage : crxb_pkg

// *** rtl/crxb_buf_mem.sv ***
// Purpose: storage for the two receive buffers, one whole frame per word
// Assumes: whole-frame write in one cycle
// Notes: read data registered, one cycle latency
`timescale 1ns/1ns
`default_nettype none
`include "crxb_defines.svh"

module crxb_buf_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic wr_addr,
  input wire logic [`CRXB_AB_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_addr,
  output logic [`CRXB_AB_W-1:0] rd_data
);
  logic [`CRXB_AB_W-1:0] mem_ff [2];
  logic [`CRXB_AB_W-1:0] nxt_mem [2];
  logic [`CRXB_AB_W-1:0] rd_ff;
  logic [`CRXB_AB_W-1:0] nxt_rd;

  always_comb begin
    nxt_mem = mem_ff;
    if (wr_en) begin
      nxt_mem[wr_addr] = wr_data;
    end
    // read sees the old word if written the same cycle
    nxt_rd = rd_en ? mem_ff[rd_addr] : rd_ff;
  end

  always_ff @(posedge clk) begin
    mem_ff <= nxt_mem;
    if (!nrst) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign rd_data = rd_ff;

endmodule : crxb_buf_mem
`default_nettype wire

// *** rtl/crxb_filter.sv ***
// Purpose: one acceptance filter compare against the assembled frame
// Assumes: id is sid in the upper 11 bits, eid in the lower 18
// Notes: purely combinational, one instance per filter
`timescale 1ns/1ns
`default_nettype none
`include "crxb_defines.svh"

module crxb_filter import crxb_pkg::*; (
  input wire logic [`CRXB_ID_W-1:0] frm_id,
  input wire logic frm_ext,
  input wire crxb_filt_t filt,
  input wire logic [`CRXB_ID_W-1:0] mask,
  input wire crxb_rxm_t mode,
  output logic hit
);
  logic [`CRXB_ID_W-1:0] cmp_bits;
  logic id_ok;
  logic mode_ok;

  always_comb begin
    // standard frames carry no eid, so only the sid bits take part
    cmp_bits = frm_ext ? mask : {mask[`CRXB_ID_W-1 -: `CRXB_SID_W],
                                 {`CRXB_EID_W{1'b0}}};
    id_ok = ((frm_id ^ filt.id) & cmp_bits) == '0;
    case (mode)
      CRXB_RXM_FILT: mode_ok = (filt.ext == frm_ext);
      CRXB_RXM_STD: mode_ok = !frm_ext && !filt.ext;
      CRXB_RXM_EXT: mode_ok = frm_ext && filt.ext;
      default: mode_ok = 1'b0;
    endcase
    hit = id_ok && mode_ok;
  end

endmodule : crxb_filter
`default_nettype wire

// *** rtl/crxb_top.sv ***
// Purpose: receive buffering: assembly buffer, filtering, two rx buffers
// Assumes: engine writes assembly bytes, then pulses end or error
// Notes: control and status bits are plain ports, no register bus
`timescale 1ns/1ns
`default_nettype none
`include "crxb_defines.svh"

module crxb_top import crxb_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pe_wr,
  input wire logic [3:0] pe_idx,
  input wire logic [7:0] pe_byte,
  input wire logic pe_eof,
  input wire logic pe_err,
  input wire crxb_filt_t [`CRXB_NFILT-1:0] filt_cfg,
  input wire logic [1:0][`CRXB_ID_W-1:0] acc_mask,
  input wire crxb_rxm_t rx_accept_mode0,
  input wire crxb_rxm_t rx_accept_mode1,
  input wire logic rollover_en,
  input wire logic [1:0] rx_full_irq_enable,
  input wire logic [1:0] host_clr_flag,
  input wire logic [1:0] full_pin_enable,
  input wire logic [1:0] full_pin_irq_mode,
  input wire logic [1:0] full_pin_level,
  input wire logic host_rd,
  input wire logic host_rd_buf,
  input wire logic [3:0] host_rd_idx,
  output logic [1:0] rx_full_flag,
  output logic int_n,
  output logic buf0_full_pin_n,
  output logic buf1_full_pin_n,
  output logic buf0_full_pin_oe,
  output logic buf1_full_pin_oe,
  output logic [7:0] rx_buffer_control0,
  output logic [7:0] rx_buffer_control1,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  logic [7:0] ab_ff [`CRXB_AB_BYTES];
  logic [7:0] nxt_ab [`CRXB_AB_BYTES];
  logic [`CRXB_AB_W-1:0] ab_flat;
  logic [`CRXB_ID_W-1:0] frm_id;
  logic frm_ext;
  logic frm_rtr;
  logic [`CRXB_NFILT-1:0] hit;
  logic any0, any1, acc0, acc1, to0, to1, roll;
  logic [2:0] fnum0, fnum1;
  logic wr_en, wr_addr;
  logic [1:0] flag_ff, nxt_flag;
  logic int_n_ff, nxt_int_n;
  logic [1:0] pin_ff, nxt_pin, oe_ff, nxt_oe;
  logic rtr0_ff, nxt_rtr0, rtr1_ff, nxt_rtr1, hit0_ff, nxt_hit0;
  logic [2:0] hit1_ff, nxt_hit1;
  logic [7:0] ctl0_ff, nxt_ctl0, ctl1_ff, nxt_ctl1;
  logic [`CRXB_AB_W-1:0] mem_rd;
  logic rd_pend_ff, nxt_rd_pend, rd_valid_ff, nxt_rd_valid;
  logic [3:0] rd_idx_ff, nxt_rd_idx;
  logic [7:0] rd_data_ff, nxt_rd_data;

  always_comb begin
    nxt_ab = ab_ff;
    if (pe_wr && pe_idx < 4'(`CRXB_AB_BYTES)) begin
      nxt_ab[pe_idx] = pe_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ab_ff <= '{default: `CRXB_BYTE_ZERO};
    end else begin
      ab_ff <= nxt_ab;
    end
  end

  always_comb begin
    for (int i = 0; i < `CRXB_AB_BYTES; i++) begin
      ab_flat[8*i +: 8] = ab_ff[i];
    end
    frm_ext = ab_ff[`CRXB_IDX_SIDL][`CRXB_SIDL_EXT_BIT];
    frm_id = {ab_ff[`CRXB_IDX_SIDH], ab_ff[`CRXB_IDX_SIDL][7:5],
              ab_ff[`CRXB_IDX_SIDL][1:0], ab_ff[`CRXB_IDX_EID8],
              ab_ff[`CRXB_IDX_EID0]};
    frm_rtr = frm_ext ? ab_ff[`CRXB_IDX_DLC][`CRXB_DLC_RTR_BIT]
                      : ab_ff[`CRXB_IDX_SIDL][`CRXB_SIDL_SRR_BIT];
  end

  for (genvar g = 0; g < `CRXB_NFILT; g++) begin : g_filt
    crxb_filter u_filt (
      .frm_id(frm_id),
      .frm_ext(frm_ext),
      .filt(filt_cfg[g]),
      .mask(acc_mask[g >= `CRXB_B0_NFILT]),
      .mode(g < `CRXB_B0_NFILT ? rx_accept_mode0 : rx_accept_mode1),
      .hit(hit[g])
    );
  end

  always_comb begin
    any0 = |hit[`CRXB_B0_NFILT-1:0];
    any1 = |hit[`CRXB_NFILT-1:`CRXB_B0_NFILT];
    fnum0 = 3'h0;
    fnum1 = 3'h0;
    for (int i = `CRXB_B0_NFILT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        fnum0 = 3'(i);
      end
    end
    for (int i = `CRXB_NFILT - 1; i >= `CRXB_B0_NFILT; i--) begin
      if (hit[i]) begin
        fnum1 = 3'(i);
      end
    end
    acc0 = (rx_accept_mode0 == CRXB_RXM_ANY) ? (pe_eof || pe_err)
                                             : (pe_eof && any0);
    acc1 = (rx_accept_mode1 == CRXB_RXM_ANY) ? (pe_eof || pe_err)
                                             : (pe_eof && any1);
    to0 = acc0 && !flag_ff[0];
    roll = acc0 && flag_ff[0] && rollover_en && !flag_ff[1];
    to1 = !to0 && (roll || (acc1 && !flag_ff[1]));
    wr_en = to0 || to1;
    wr_addr = to1;
  end

  crxb_buf_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(ab_flat),
    .rd_en(host_rd),
    .rd_addr(host_rd_buf),
    .rd_data(mem_rd)
  );

  always_comb begin
    nxt_flag = (flag_ff & ~host_clr_flag) | {to1, to0};
    nxt_int_n = !(|(nxt_flag & rx_full_irq_enable));
    nxt_oe = full_pin_enable;
    for (int b = 0; b < 2; b++) begin
      if (full_pin_enable[b] && full_pin_irq_mode[b]) begin
        nxt_pin[b] = !nxt_flag[b];
      end else if (full_pin_enable[b]) begin
        nxt_pin[b] = full_pin_level[b];
      end else begin
        nxt_pin[b] = 1'b1;
      end
    end
    nxt_rtr0 = to0 ? frm_rtr : rtr0_ff;
    nxt_hit0 = to0 ? fnum0[0] : hit0_ff;
    nxt_rtr1 = to1 ? frm_rtr : rtr1_ff;
    nxt_hit1 = to1 ? (roll ? fnum0 : fnum1) : hit1_ff;
    nxt_ctl0 = {1'b0, rx_accept_mode0, 1'b0, nxt_rtr0, rollover_en,
                rollover_en, nxt_hit0};
    nxt_ctl1 = {1'b0, rx_accept_mode1, 1'b0, nxt_rtr1, nxt_hit1};
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_ff <= 2'h0;
      int_n_ff <= 1'b1;
      pin_ff <= 2'h3;
      oe_ff <= 2'h0;
      rtr0_ff <= 1'b0;
      hit0_ff <= 1'b0;
      rtr1_ff <= 1'b0;
      hit1_ff <= 3'h0;
      ctl0_ff <= `CRXB_CTRL_RST;
      ctl1_ff <= `CRXB_CTRL_RST;
    end else begin
      flag_ff <= nxt_flag;
      int_n_ff <= nxt_int_n;
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
      rtr0_ff <= nxt_rtr0;
      hit0_ff <= nxt_hit0;
      rtr1_ff <= nxt_rtr1;
      hit1_ff <= nxt_hit1;
      ctl0_ff <= nxt_ctl0;
      ctl1_ff <= nxt_ctl1;
    end
  end

  // read pipeline: memory word, then byte pick
  always_comb begin
    nxt_rd_pend = host_rd;
    nxt_rd_idx = host_rd ? host_rd_idx : rd_idx_ff;
    nxt_rd_valid = rd_pend_ff;
    nxt_rd_data = rd_data_ff;
    if (rd_pend_ff) begin
      nxt_rd_data = (rd_idx_ff < 4'(`CRXB_AB_BYTES))
                    ? mem_rd[8*rd_idx_ff +: 8] : `CRXB_BYTE_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_pend_ff <= 1'b0;
      rd_idx_ff <= 4'h0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= `CRXB_BYTE_ZERO;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      rd_idx_ff <= nxt_rd_idx;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rx_full_flag = flag_ff;
  assign int_n = int_n_ff;
  assign buf0_full_pin_n = pin_ff[0];
  assign buf1_full_pin_n = pin_ff[1];
  assign buf0_full_pin_oe = oe_ff[0];
  assign buf1_full_pin_oe = oe_ff[1];
  assign rx_buffer_control0 = ctl0_ff;
  assign rx_buffer_control1 = ctl1_ff;
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;

  // checks on the design's own signals and outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_FLAG_SET: assert property (wr_en |=> rx_full_flag[$past(wr_addr)])
    else $error("flag not set after transfer");
  AST_LOCKOUT: assert property (wr_en |-> !flag_ff[wr_addr])
    else $error("write into locked buffer");
  // int_n and the flags register on the same edge, enables one cycle back
  AST_INT: assert property (
    ##1 int_n == !(|(rx_full_flag & $past(rx_full_irq_enable))))
    else $error("interrupt output wrong");
  AST_PRIO: assert property (
    pe_eof && any0 && !flag_ff[0] |-> wr_en && !wr_addr)
    else $error("buffer 0 not served first");
  AST_ROLL: assert property (
    pe_eof && any0 && flag_ff[0] && rollover_en && !flag_ff[1]
    |=> rx_full_flag[1] && rx_buffer_control1[2:1] == 2'h0)
    else $error("rollover failed");
  AST_ANY: assert property (
    pe_eof && rx_accept_mode0 == CRXB_RXM_ANY && !flag_ff[0]
    |-> wr_en && !wr_addr)
    else $error("mode 11 did not accept");
  AST_ERR: assert property (
    pe_err && !pe_eof && rx_accept_mode0 != CRXB_RXM_ANY
    && rx_accept_mode1 != CRXB_RXM_ANY |-> !wr_en)
    else $error("error frame stored outside mode 11");
  AST_PIN_IRQ: assert property (
    full_pin_enable[0] && full_pin_irq_mode[0]
    |=> buf0_full_pin_n == !rx_full_flag[0])
    else $error("pin 0 not following flag");
  AST_PIN_OUT: assert property (
    full_pin_enable[1] && !full_pin_irq_mode[1]
    |=> buf1_full_pin_n == $past(full_pin_level[1]) && buf1_full_pin_oe)
    else $error("pin 1 not following level");
  AST_DROP: assert property (flag_ff == 2'h3 |-> !wr_en)
    else $error("frame stored with both buffers locked");
  AST_READ: assert property (host_rd |-> ##2 rd_valid)
    else $error("read answer late");

  COV_ROLL: cover property (roll);
  COV_BUF1: cover property (to1 && !roll);
  COV_ERR: cover property (pe_err && wr_en);
  COV_READ_WHILE_RX: cover property (host_rd && wr_en);

endmodule : crxb_top
`default_nettype wire

// *** verif/crxb_pe_model.sv ***
// Purpose: protocol engine model feeding the assembly buffer
// Assumes: one byte per cycle in index order, then one end pulse, or one error pulse when err is set
// Notes: the byte line released after a frame shows a changed value
`timescale 1ns/1ns
`default_nettype none
`include "crxb_defines.svh"

module crxb_pe_model (
  input wire logic clk,
  output logic pe_wr,
  output logic [3:0] pe_idx,
  output logic [7:0] pe_byte,
  output logic pe_eof,
  output logic pe_err
);
  initial begin
    pe_wr = 1'b0;
    pe_idx = 4'hf;
    pe_byte = 8'h00;
    pe_eof = 1'b0;
    pe_err = 1'b0;
  end

  // n below 13 models a frame cut short by an error
  task automatic send(input logic [`CRXB_AB_W-1:0] f, input int n,
                      input logic err);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pe_wr <= 1'b1;
      pe_idx <= 4'(i);
      pe_byte <= f[8*i +: 8];
    end
    @(posedge clk);
    pe_wr <= 1'b0;
    // idle data inverted so a stale byte is never trusted
    pe_byte <= ~pe_byte;
    pe_eof <= ~err;
    pe_err <= err;
    @(posedge clk);
    pe_eof <= 1'b0;
    pe_err <= 1'b0;
  endtask : send
endmodule : crxb_pe_model
`default_nettype wire

// *** verif/tb_can_receive_buffering.sv ***
// Purpose: self-checking bench for the receive buffering block
// Assumes: standard frames, sid compared under an all-sid mask
// Notes: random data bytes and random buffer 1 filter, fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "crxb_defines.svh"

module tb_can_receive_buffering import crxb_pkg::*; ();
  logic clk, nrst, rollover_en, host_rd, host_rd_buf;
  logic [3:0] host_rd_idx;
  logic [1:0] rx_full_irq_enable, host_clr_flag, full_pin_enable;
  logic [1:0] full_pin_irq_mode, full_pin_level, rx_full_flag;
  crxb_filt_t [`CRXB_NFILT-1:0] filt_cfg;
  logic [1:0][`CRXB_ID_W-1:0] acc_mask;
  crxb_rxm_t rx_accept_mode0, rx_accept_mode1;
  logic pe_wr, pe_eof, pe_err, int_n, rd_valid;
  logic buf0_full_pin_n, buf1_full_pin_n, buf0_full_pin_oe, buf1_full_pin_oe;
  logic [3:0] pe_idx;
  logic [7:0] pe_byte, rx_buffer_control0, rx_buffer_control1, rd_data;
  logic [`CRXB_AB_W-1:0] fa, fb, fc, fx;
  int miscompares, n_tests, k;

  crxb_pe_model peng (.clk, .pe_wr, .pe_idx, .pe_byte, .pe_eof, .pe_err);
  crxb_top dut_u (.clk, .nrst, .pe_wr, .pe_idx, .pe_byte, .pe_eof, .pe_err,
    .filt_cfg, .acc_mask, .rx_accept_mode0, .rx_accept_mode1,
    .rollover_en, .rx_full_irq_enable, .host_clr_flag, .full_pin_enable,
    .full_pin_irq_mode, .full_pin_level, .host_rd, .host_rd_buf,
    .host_rd_idx, .rx_full_flag, .int_n, .buf0_full_pin_n,
    .buf1_full_pin_n, .buf0_full_pin_oe, .buf1_full_pin_oe,
    .rx_buffer_control0, .rx_buffer_control1, .rd_data, .rd_valid);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic crxb_filt_t sf(input logic [10:0] s);
    return {1'b0, s, 18'h0};
  endfunction : sf

  // standard frame, eight random data bytes
  function automatic logic [`CRXB_AB_W-1:0] mk(input logic [10:0] s);
    logic [`CRXB_AB_W-1:0] f;
    f = `CRXB_AB_W'({$urandom, $urandom, $urandom, $urandom});
    f[39:0] = {8'h08, 16'h0000, s[2:0], 5'h00, s[10:3]};
    return f;
  endfunction : mk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cbuf(input logic b, input logic [`CRXB_AB_W-1:0] f);
    int w;
    for (int i = 0; i < `CRXB_AB_BYTES; i++) begin
      @(posedge clk);
      host_rd <= 1'b1;
      host_rd_buf <= b;
      host_rd_idx <= 4'(i);
      @(posedge clk);
      host_rd <= 1'b0;
      // answer is due one edge after the request is taken
      for (w = 0; w < 4; w++) begin
        @(posedge clk);
        #1;
        if (rd_valid === 1'b1) break;
      end
      if (w == 4) begin
        miscompares++;
        test_done();
      end
      chk("rd_data", f[8*i +: 8], rd_data);
    end
  endtask : cbuf

  task automatic clr(input logic [1:0] m);
    @(posedge clk);
    host_clr_flag <= m;
    @(posedge clk);
    host_clr_flag <= 2'h0;
    #1;
  endtask : clr

  task automatic flag(input logic [1:0] e);
    #1;
    chk("rx_full_flag", 8'(e), 8'(rx_full_flag));
  endtask : flag

  initial begin
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h30e6));
    {nrst, host_rd, host_rd_buf, rollover_en} = 4'h0;
    host_rd_idx = 4'h0;
    {rx_full_irq_enable, full_pin_enable, full_pin_irq_mode} = 6'h3f;
    {host_clr_flag, full_pin_level} = 4'h0;
    rx_accept_mode0 = CRXB_RXM_FILT;
    rx_accept_mode1 = CRXB_RXM_FILT;
    acc_mask = {2{11'h7ff, 18'h0}};
    for (k = 2; k < `CRXB_NFILT; k++) filt_cfg[k] = sf(11'h200 | 11'(k));
    filt_cfg[0] = sf(11'h100);
    filt_cfg[1] = sf(11'h123);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("int_n", 8'h01, 8'(int_n));
    chk("pins", 8'h03, {6'h0, buf1_full_pin_n, buf0_full_pin_n});
    chk("ctl0", 8'h00, rx_buffer_control0);
    flag(2'h0);
    $display("test reset done");
    fa = mk(11'h123);
    peng.send(fa, 13, 1'b0);
    flag(2'h1);
    chk("int_n", 8'h00, 8'(int_n));
    chk("pin0", 8'h00, 8'(buf0_full_pin_n));
    chk("ctl0", 8'h01, rx_buffer_control0);
    cbuf(1'b0, fa);
    $display("test accept done");
    fb = mk(11'h100);
    peng.send(fb, 13, 1'b0);
    flag(2'h1);
    k = 2 + $urandom % 4;
    fc = mk(11'h200 | 11'(k));
    peng.send(fc, 13, 1'b0);
    flag(2'h3);
    chk("ctl1", 8'(k), rx_buffer_control1);
    chk("pin1", 8'h00, 8'(buf1_full_pin_n));
    peng.send(fb, 13, 1'b0);
    flag(2'h3);
    cbuf(1'b0, fa);
    cbuf(1'b1, fc);
    $display("test lockout done");
    clr(2'h2);
    chk("pin1", 8'h01, 8'(buf1_full_pin_n));
    @(posedge clk);
    rollover_en <= 1'b1;
    peng.send(fb, 13, 1'b0);
    flag(2'h3);
    chk("ctl1", 8'h00, rx_buffer_control1);
    chk("ctl0", 8'h07, rx_buffer_control0);
    cbuf(1'b1, fb);
    $display("test rollover done");
    clr(2'h3);
    @(posedge clk);
    rollover_en <= 1'b0;
    peng.send(fa, 13, 1'b1);
    flag(2'h0);
    @(posedge clk);
    rx_accept_mode1 <= CRXB_RXM_ANY;
    fx = mk(11'h7ff);
    peng.send(fx, 6, 1'b1);
    flag(2'h2);
    cbuf(1'b1, {fa[103:48], fx[47:0]});
    $display("test receive any done");
    clr(2'h2);
    @(posedge clk);
    rx_accept_mode1 <= CRXB_RXM_FILT;
    rx_accept_mode0 <= CRXB_RXM_EXT;
    rx_full_irq_enable <= 2'h2;
    peng.send(fa, 13, 1'b0);
    flag(2'h0);
    @(posedge clk);
    rx_accept_mode0 <= CRXB_RXM_STD;
    peng.send(fa, 13, 1'b0);
    flag(2'h1);
    chk("ctl0", 8'h21, rx_buffer_control0);
    chk("int_n", 8'h01, 8'(int_n));
    $display("test modes done");
    // levels changed one bit at a time, as a bit-modify host does
    @(posedge clk);
    full_pin_irq_mode <= 2'h0;
    full_pin_level <= 2'h1;
    repeat (2) @(posedge clk);
    full_pin_level <= 2'h3;
    #1;
    chk("pins", 8'h01, {6'h0, buf1_full_pin_n, buf0_full_pin_n});
    repeat (2) @(posedge clk);
    full_pin_enable <= 2'h2;
    #1;
    chk("pins", 8'h03, {6'h0, buf1_full_pin_n, buf0_full_pin_n});
    repeat (2) @(posedge clk);
    #1;
    chk("oe", 8'h02, {6'h0, buf1_full_pin_oe, buf0_full_pin_oe});
    $display("test pins done");
    clr(2'h1);
    @(posedge clk);
    rx_accept_mode0 <= CRXB_RXM_ANY;
    rx_accept_mode1 <= CRXB_RXM_EXT;
    // remote request on a standard frame that no filter knows
    fx = mk(11'h055);
    fx[12] = 1'b1;
    peng.send(fx, 13, 1'b0);
    flag(2'h1);
    chk("ctl0", 8'h0d, 8'(rx_buffer_control0[6:3]));
    cbuf(1'b0, fx);
    peng.send(fc, 13, 1'b0);
    flag(2'h1);
    $display("test receive all done");
    test_done();
  end
endmodule : tb_can_receive_buffering
`default_nettype wire
